// ---- design/acsr_device.sv ----
// Converter end: conversion timing, sleep mode and serial result shifter
module acsr_device #(
   parameter bit BIPOLAR = 1'b0, // Two's complement coding when set
   parameter int unsigned CONV_CYC = acsr_pkg::CONV_CYC, // Busy length
   parameter int unsigned WAKE_CYC = acsr_pkg::WAKE_CYC // Wake-up length
) (
   input wire logic CLK, // System clock, 50 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   acsr_if.dev LINK, // Link to the serial master
   input wire logic [11:0] SAMPLE_IN, // Quantised input level, 0..4095
   output logic TRACKING, // Track/hold is tracking
   output logic ASLEEP, // Powered down in auto-sleep mode
   output logic MODE_SLEEP // Auto-sleep mode chosen last time
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
   logic ck_s1_ff, ck_s2_ff, ck_s3_ff;
   logic cs_fall, cs_rise, ck_fall, ck_rise;

   // Both link inputs come from another domain; third stage is history
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cs_s1_ff <= acsr_pkg::CONVERT_IDLE;
         cs_s2_ff <= acsr_pkg::CONVERT_IDLE;
         cs_s3_ff <= acsr_pkg::CONVERT_IDLE;
         ck_s1_ff <= acsr_pkg::SCLK_IDLE;
         ck_s2_ff <= acsr_pkg::SCLK_IDLE;
         ck_s3_ff <= acsr_pkg::SCLK_IDLE;
      end else begin
         cs_s1_ff <= LINK.convert_start_n;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         ck_s1_ff <= LINK.serial_clock;
         ck_s2_ff <= ck_s1_ff;
         ck_s3_ff <= ck_s2_ff;
      end
   end

   // Edge detection only on the settled stages
   assign cs_fall = cs_s3_ff & ~cs_s2_ff;
   assign cs_rise = ~cs_s3_ff & cs_s2_ff;
   assign ck_fall = ck_s3_ff & ~ck_s2_ff;
   assign ck_rise = ~ck_s3_ff & ck_s2_ff;

   // ---------------------------------------------------------------
   // Conversion control
   // ---------------------------------------------------------------
   acsr_pkg::acsr_dev_state_t state_ff, nxt_state;
   logic [acsr_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic busy_ff, nxt_busy;
   logic mode_ff, nxt_mode;
   logic [11:0] held_ff, nxt_held;
   logic [11:0] result_ff, nxt_result;
   logic [11:0] coded;

   // Coding of the held sample; bipolar flips the sign of mid-scale
   assign coded = BIPOLAR ? {~held_ff[11], held_ff[10:0]}
                          : held_ff;

   // Conversion is timed by the local clock, never by the serial clock
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      nxt_mode = mode_ff;
      nxt_held = held_ff;
      nxt_result = result_ff;
      case (state_ff)
         acsr_pkg::ACSR_DEV_TRACK: begin
            if (cs_fall) begin
               nxt_state = acsr_pkg::ACSR_DEV_CONV;
               nxt_busy = 1'b1;
               nxt_held = SAMPLE_IN;
               nxt_cnt = '0;
            end
         end
         acsr_pkg::ACSR_DEV_CONV: begin
            if (cnt_ff == acsr_pkg::CNT_W'(CONV_CYC - 1)) begin
               nxt_busy = 1'b0;
               nxt_result = coded;
               nxt_cnt = '0;
               // Convert still low here means the sleeping mode
               nxt_mode = ~cs_s2_ff;
               nxt_state = cs_s2_ff ? acsr_pkg::ACSR_DEV_TRACK
                                    : acsr_pkg::ACSR_DEV_SLEEP;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         acsr_pkg::ACSR_DEV_SLEEP: begin
            if (cs_rise) begin
               nxt_state = acsr_pkg::ACSR_DEV_WAKE;
               nxt_cnt = '0;
            end
         end
         acsr_pkg::ACSR_DEV_WAKE: begin
            // A fall during wake-up is honoured only once awake
            if (cnt_ff == acsr_pkg::CNT_W'(WAKE_CYC - 1)) begin
               nxt_cnt = '0;
               if (!cs_s2_ff) begin
                  nxt_state = acsr_pkg::ACSR_DEV_CONV;
                  nxt_busy = 1'b1;
                  nxt_held = SAMPLE_IN;
               end else begin
                  // Still high: the coming fall starts the hold
                  nxt_state = acsr_pkg::ACSR_DEV_TRACK;
               end
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         default: nxt_state = acsr_pkg::ACSR_DEV_TRACK;
      endcase
   end

   // Registers of the conversion control
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_ff <= acsr_pkg::ACSR_DEV_TRACK;
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         mode_ff <= 1'b0;
         held_ff <= '0;
         result_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
         mode_ff <= nxt_mode;
         held_ff <= nxt_held;
         result_ff <= nxt_result;
      end
   end

   // ---------------------------------------------------------------
   // Serial result shifter
   // ---------------------------------------------------------------
   logic [3:0] bit_ff, nxt_bit;
   logic drv_ff, nxt_drv;
   logic sdo_ff, nxt_sdo;
   logic [acsr_pkg::FRAME_BITS-1:0] frame;
   logic [3:0] bit_inc;

   assign frame = {acsr_pkg::LEAD_ZERO_BITS'(0), result_ff};
   assign bit_inc = bit_ff + 4'h1;

   // Runs in every state, so a sleeping converter still answers
   always_comb begin
      nxt_bit = bit_ff;
      nxt_drv = drv_ff;
      nxt_sdo = sdo_ff;
      if (cs_fall) begin
         // Known start each conversion; a read across this is lost
         nxt_bit = 4'h0;
         nxt_drv = 1'b0;
         nxt_sdo = 1'b0;
      end else if (ck_rise && !drv_ff) begin
         // First leading zero leaves on the first rising edge
         nxt_drv = 1'b1;
         nxt_sdo = frame[4'(acsr_pkg::FRAME_BITS - 1) - bit_ff];
      end else if (ck_fall && drv_ff) begin
         if (bit_ff == 4'(acsr_pkg::FRAME_BITS - 1)) begin
            nxt_bit = 4'h0;
            nxt_drv = 1'b0;
            nxt_sdo = 1'b0;
         end else begin
            nxt_bit = bit_inc;
            nxt_sdo = frame[4'(acsr_pkg::FRAME_BITS - 1) - bit_inc];
         end
      end
   end

   // Registers of the shifter
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bit_ff <= 4'h0;
         drv_ff <= 1'b0;
         sdo_ff <= 1'b0;
      end else begin
         bit_ff <= nxt_bit;
         drv_ff <= nxt_drv;
         sdo_ff <= nxt_sdo;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign LINK.serial_result_out = sdo_ff;
   assign LINK.serial_result_oe_n = ~drv_ff;
   assign LINK.conversion_busy = busy_ff;
   // Hold lasts exactly as long as busy
   assign TRACKING = ~busy_ff;
   assign ASLEEP = (state_ff == acsr_pkg::ACSR_DEV_SLEEP);
   assign MODE_SLEEP = mode_ff;
endmodule

// ---- pkg/acsr_pkg.sv ----
// Shared constants and types for the converter control and serial readout
package acsr_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned CONV_TIME_NS = 3800;
   localparam int unsigned WAKE_TIME_NS = 6000;
   localparam int unsigned SETTLE_TIME_NS = 300;
   localparam int unsigned SCLK_MAX_HZ = 15000000;
   // Pin to registered action: two sync stages, edge stage, output stage
   localparam int unsigned EDGE_LAT_CYC = 4;
   // Longest times round down, least times round up
   localparam int unsigned CONV_CYC =
      CONV_TIME_NS / CLK_PERIOD_NS - EDGE_LAT_CYC;
   localparam int unsigned WAKE_CYC =
      (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - EDGE_LAT_CYC;
   localparam int unsigned SETTLE_CYC =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SCLK_HALF_CYC = 8;
   localparam int unsigned CONVERT_PULSE_CYC = 5;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int unsigned RESULT_BITS = 12;
   localparam int unsigned LEAD_ZERO_BITS = 4;
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned CNT_W = 9;
   // Idle levels of the link after reset
   localparam logic CONVERT_IDLE = 1'b1;
   localparam logic SCLK_IDLE = 1'b0;
   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ACSR_DEV_TRACK,
      ACSR_DEV_CONV,
      ACSR_DEV_SLEEP,
      ACSR_DEV_WAKE
   } acsr_dev_state_t;
   typedef enum logic [2:0] {
      ACSR_HST_IDLE,
      ACSR_HST_RISE,
      ACSR_HST_FALL,
      ACSR_HST_WAIT_DONE,
      ACSR_HST_READ,
      ACSR_HST_GAP
   } acsr_hst_state_t;
endpackage

// ---- pkg/acsr_if.sv ----
// Link wires between the converter end and the serial master end
interface acsr_if;
   logic convert_start_n; // Convert request, active low
   logic serial_clock; // Read clock from the master
   logic serial_result_out; // Data driven by the converter
   logic serial_result_oe_n; // Converter drives data when low
   logic conversion_busy; // Conversion in progress
   logic serial_result_line; // Resolved data wire

   // Undriven line reads low, as through a weak pull-down
   assign serial_result_line = ~serial_result_oe_n & serial_result_out;

   modport dev (
      input convert_start_n,
      input serial_clock,
      output serial_result_out,
      output serial_result_oe_n,
      output conversion_busy
   );
   modport host (
      output convert_start_n,
      output serial_clock,
      input serial_result_line,
      input conversion_busy
   );
endinterface

// ---- design/acsr_host.sv ----
// Serial master end: issues convert pulses and reads 16-bit frames
module acsr_host #(
   parameter int unsigned HALF_CYC = acsr_pkg::SCLK_HALF_CYC, // Clock half
   parameter int unsigned PULSE_CYC = acsr_pkg::CONVERT_PULSE_CYC, // Edge gap
   parameter int unsigned SETTLE_CYC = acsr_pkg::SETTLE_CYC // Read to convert
) (
   input wire logic CLK, // System clock, 50 MHz
   input wire logic SYS_RST, // Synchronous reset, active high
   acsr_if.host LINK, // Link to the converter
   input wire logic START, // Request one conversion and read
   input wire logic SLEEP_MODE, // Leave convert low for auto-sleep
   output logic READY, // Idle, START accepted
   output logic [15:0] FRAME_OUT, // Last frame read, first bit at top
   output logic FRAME_VALID // One-cycle pulse with a new frame
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic bz_s1_ff, bz_s2_ff, sd_s1_ff, sd_s2_ff;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bz_s1_ff <= 1'b0;
         bz_s2_ff <= 1'b0;
         sd_s1_ff <= 1'b0;
         sd_s2_ff <= 1'b0;
      end else begin
         bz_s1_ff <= LINK.conversion_busy;
         bz_s2_ff <= bz_s1_ff;
         sd_s1_ff <= LINK.serial_result_line;
         sd_s2_ff <= sd_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   acsr_pkg::acsr_hst_state_t state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [4:0] pulse_ff, nxt_pulse;
   logic mode_ff, nxt_mode;
   logic cs_ff, nxt_cs;
   logic ck_ff, nxt_ck;
   logic [15:0] shift_ff, nxt_shift;
   logic [15:0] frame_ff, nxt_frame;
   logic valid_ff, nxt_valid;

   // Serial clock is a divided local clock; half of 8 gives 3.125 MHz,
   // slow enough that synchronised data settles before each sample
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_pulse = pulse_ff;
      nxt_mode = mode_ff;
      nxt_cs = cs_ff;
      nxt_ck = ck_ff;
      nxt_shift = shift_ff;
      nxt_frame = frame_ff;
      nxt_valid = 1'b0;
      case (state_ff)
         acsr_pkg::ACSR_HST_IDLE: begin
            if (START) begin
               nxt_mode = SLEEP_MODE;
               nxt_cs = 1'b1; // Wakes a sleeping converter
               nxt_cnt = '0;
               nxt_state = acsr_pkg::ACSR_HST_RISE;
            end
         end
         acsr_pkg::ACSR_HST_RISE: begin
            if (cnt_ff == 8'(PULSE_CYC - 1)) begin
               nxt_cs = 1'b0; // Serial clock is low here
               nxt_state = acsr_pkg::ACSR_HST_FALL;
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         acsr_pkg::ACSR_HST_FALL: begin
            // Low until busy is seen, so a pending wake still converts
            if (bz_s2_ff) begin
               nxt_cs = ~mode_ff; // Level at end sets mode
               nxt_state = acsr_pkg::ACSR_HST_WAIT_DONE;
            end
         end
         acsr_pkg::ACSR_HST_WAIT_DONE: begin
            if (!bz_s2_ff) begin
               nxt_cnt = '0;
               nxt_pulse = '0;
               nxt_state = acsr_pkg::ACSR_HST_READ;
            end
         end
         acsr_pkg::ACSR_HST_READ: begin
            if (cnt_ff == 8'(HALF_CYC - 1)) begin
               nxt_cnt = '0;
               if (!ck_ff) begin
                  nxt_ck = 1'b1;
               end else begin
                  // Sample at our falling edge, before the bit moves on
                  nxt_ck = 1'b0;
                  nxt_shift = {shift_ff[14:0], sd_s2_ff};
                  nxt_pulse = pulse_ff + 5'h01;
                  if (pulse_ff == 5'(acsr_pkg::FRAME_BITS - 1)) begin
                     nxt_frame = {shift_ff[14:0], sd_s2_ff};
                     nxt_valid = 1'b1;
                     nxt_state = acsr_pkg::ACSR_HST_GAP;
                  end
               end
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         acsr_pkg::ACSR_HST_GAP: begin
            // Settling time before any new convert edge
            if (cnt_ff == 8'(SETTLE_CYC - 1)) begin
               nxt_state = acsr_pkg::ACSR_HST_IDLE;
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         default: nxt_state = acsr_pkg::ACSR_HST_IDLE;
      endcase
   end

   // Registers of the sequencer
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_ff <= acsr_pkg::ACSR_HST_IDLE;
         cnt_ff <= '0;
         pulse_ff <= '0;
         mode_ff <= 1'b0;
         cs_ff <= acsr_pkg::CONVERT_IDLE;
         ck_ff <= acsr_pkg::SCLK_IDLE;
         shift_ff <= '0;
         frame_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         pulse_ff <= nxt_pulse;
         mode_ff <= nxt_mode;
         cs_ff <= nxt_cs;
         ck_ff <= nxt_ck;
         shift_ff <= nxt_shift;
         frame_ff <= nxt_frame;
         valid_ff <= nxt_valid;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign LINK.convert_start_n = cs_ff;
   assign LINK.serial_clock = ck_ff;
   assign READY = (state_ff == acsr_pkg::ACSR_HST_IDLE);
   assign FRAME_OUT = frame_ff;
   assign FRAME_VALID = valid_ff;
endmodule

// ---- verification/acsr_properties.sv ----
// Concurrent checks on the link between converter and serial master
module acsr_properties #(
   parameter int unsigned CONV_CYC = acsr_pkg::CONV_CYC, // Busy length
   parameter int unsigned WAKE_CYC = acsr_pkg::WAKE_CYC, // Wake length
   parameter int unsigned SETTLE_CYC = acsr_pkg::SETTLE_CYC // Read gap
) (
   input wire logic CLK, // System clock
   input wire logic SYS_RST, // Synchronous reset
   input wire logic convert_start_n, // Convert request
   input wire logic serial_clock, // Read clock
   input wire logic serial_result_out, // Data bit
   input wire logic serial_result_oe_n, // Data enable, low
   input wire logic conversion_busy, // Busy flag
   input wire logic serial_result_line // Resolved data
);
   localparam int WAKE_LO = WAKE_CYC;
   localparam int WAKE_HI = WAKE_CYC + 8;
   logic cv_q_ff, ck_q_ff, bz_q_ff, mode_sleep_ff;
   logic nxt_mode_sleep;
   logic [4:0] fall_cnt_ff, nxt_fall_cnt;
   logic [7:0] gap_ff, nxt_gap;
   logic [8:0] busy_cnt_ff, nxt_busy_cnt;

   // ---------------------------------------------------------
   // Helper state
   // ---------------------------------------------------------
   // Edges found by hand: sampled functions are barred here
   always_comb begin
      nxt_mode_sleep = mode_sleep_ff;
      if (bz_q_ff && !conversion_busy) nxt_mode_sleep = !convert_start_n;
      nxt_fall_cnt = fall_cnt_ff;
      if (cv_q_ff && !convert_start_n) nxt_fall_cnt = 5'h00;
      else if (ck_q_ff && !serial_clock) nxt_fall_cnt = fall_cnt_ff + 5'h01;
      nxt_gap = (gap_ff == 8'hff) ? gap_ff : gap_ff + 8'h01;
      if (ck_q_ff && !serial_clock) nxt_gap = 8'h00;
      nxt_busy_cnt = conversion_busy ? busy_cnt_ff + 9'h001 : 9'h000;
   end

   // Gap starts saturated so the first request is legal
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cv_q_ff <= 1'b1;
         ck_q_ff <= 1'b0;
         bz_q_ff <= 1'b0;
         mode_sleep_ff <= 1'b0;
         fall_cnt_ff <= 5'h00;
         gap_ff <= 8'hff;
         busy_cnt_ff <= 9'h000;
      end else begin
         cv_q_ff <= convert_start_n;
         ck_q_ff <= serial_clock;
         bz_q_ff <= conversion_busy;
         mode_sleep_ff <= nxt_mode_sleep;
         fall_cnt_ff <= nxt_fall_cnt;
         gap_ff <= nxt_gap;
         busy_cnt_ff <= nxt_busy_cnt;
      end
   end

   // ---------------------------------------------------------
   // Properties
   // ---------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence conv_req;
      $fell(convert_start_n) && !conversion_busy && !mode_sleep_ff;
   endsequence
   sequence wake_req;
      $rose(convert_start_n) && !conversion_busy && mode_sleep_ff;
   endsequence
   sequence read_start;
      $rose(serial_clock) && fall_cnt_ff == 5'h00;
   endsequence

   conv_start_a: assert property (conv_req |-> ##[3:5] $rose(conversion_busy))
      else $error("busy did not follow convert fall");
   busy_length_a: assert property ($fell(conversion_busy) |-> busy_cnt_ff == CONV_CYC)
      else $error("busy length wrong");
   wake_hold_a: assert property (wake_req |-> ##[WAKE_LO:WAKE_HI] $rose(conversion_busy))
      else $error("no hold after wake time");
   read_drive_a: assert property (read_start |-> ##[2:5] !serial_result_oe_n)
      else $error("data not driven on first clock");
   frame_release_a: assert property ($fell(serial_clock) && fall_cnt_ff == 5'h0f
      |-> ##[2:5] serial_result_oe_n)
      else $error("data not released after sixteenth fall");
   lead_zero_a: assert property ($fell(serial_clock) && fall_cnt_ff < 5'h04
      |-> !serial_result_line)
      else $error("leading bit not zero");
   data_hold_a: assert property (serial_clock [*7] |-> $stable(serial_result_out))
      else $error("data moved while clock high");
   clock_low_a: assert property ($fell(convert_start_n) |-> !serial_clock)
      else $error("clock high at convert fall");
   busy_quiet_a: assert property (conversion_busy |-> !serial_clock)
      else $error("read during conversion");
   settle_gap_a: assert property ($fell(convert_start_n) |-> gap_ff >= SETTLE_CYC)
      else $error("read too close to convert fall");
endmodule

// ---- verification/tb_top.sv ----
// Bench: master and converter joined, plus a converter driven by hand
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------
   // Set-up
   // ---------------------------------------------------------
   localparam int unsigned CONV = 20; // Short busy keeps runs brief
   localparam int unsigned WAKE = 30;
   typedef struct packed {
      logic sleep;
      logic [11:0] sample;
      logic [15:0] frame;
   } acsr_row_t;
   localparam acsr_row_t ROWS [5] = '{
      '{1'b0, 12'h000, 16'h0000}, '{1'b0, 12'hfff, 16'h0fff},
      '{1'b1, 12'ha5c, 16'h0a5c}, '{1'b1, 12'h001, 16'h0001},
      '{1'b0, 12'h800, 16'h0800}};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic sleep_mode = 1'b0;
   logic [11:0] sample_a = 12'h000;
   logic [11:0] sample_b = 12'h000;
   logic cv_b = 1'b1;
   logic ck_b = 1'b0;
   logic ready, frame_valid, tracking, asleep, mode_sleep, asl_b;
   logic [15:0] frame_out;
   int n_fail = 0;
   int total_checks = 0;

   acsr_if lnk_a();
   acsr_if lnk_b();
   // Second link breaks the read rules on purpose
   assign lnk_b.convert_start_n = cv_b;
   assign lnk_b.serial_clock = ck_b;
   acsr_device #(.CONV_CYC(CONV), .WAKE_CYC(WAKE)) u_acsr_device (
      .CLK(clk), .SYS_RST(sys_rst), .LINK(lnk_a), .SAMPLE_IN(sample_a),
      .TRACKING(tracking), .ASLEEP(asleep), .MODE_SLEEP(mode_sleep));
   acsr_device #(.BIPOLAR(1'b1), .CONV_CYC(CONV), .WAKE_CYC(WAKE))
      u_acsr_device_bip (.CLK(clk), .SYS_RST(sys_rst), .LINK(lnk_b),
      .SAMPLE_IN(sample_b), .TRACKING(), .ASLEEP(asl_b), .MODE_SLEEP());
   acsr_host u_acsr_host (.CLK(clk), .SYS_RST(sys_rst), .LINK(lnk_a),
      .START(start), .SLEEP_MODE(sleep_mode), .READY(ready),
      .FRAME_OUT(frame_out), .FRAME_VALID(frame_valid));
   acsr_properties #(.CONV_CYC(CONV), .WAKE_CYC(WAKE)) u_acsr_properties (
      .CLK(clk), .SYS_RST(sys_rst),
      .convert_start_n(lnk_a.convert_start_n),
      .serial_clock(lnk_a.serial_clock),
      .serial_result_out(lnk_a.serial_result_out),
      .serial_result_oe_n(lnk_a.serial_result_oe_n),
      .conversion_busy(lnk_a.conversion_busy),
      .serial_result_line(lnk_a.serial_result_line));

   // Free-running system clock
   always #10 clk = ~clk;

   // ---------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function automatic logic pick(input int which);
      case (which)
         0: return ready;
         1: return frame_valid;
         2: return lnk_b.conversion_busy;
         default: return ~lnk_b.conversion_busy;
      endcase
   endfunction

   // Bounded wait; running out counts as a mismatch
   task automatic wait_hi(input int which, input int limit, output int n);
      n = 0;
      while (pick(which) !== 1'b1 && n < limit) begin
         @(posedge clk);
         n++;
      end
      if (n >= limit) check("wait", 16'h0001, 16'h0000);
   endtask

   task automatic run_row(input acsr_row_t r);
      int n;
      wait_hi(0, 3000, n);
      sample_a <= r.sample;
      sleep_mode <= r.sleep;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_hi(1, 3000, n);
      check("frame_out", r.frame, frame_out);
      check("mode_sleep", {15'h0, r.sleep}, {15'h0, mode_sleep});
      check("asleep", {15'h0, r.sleep}, {15'h0, asleep});
      check("tracking", 16'h0001, {15'h0, tracking});
   endtask

   // cnt clock pulses; each bit taken as the clock falls
   task automatic read_b(input int cnt, output logic [15:0] w);
      w = 16'h0000;
      for (int j = 0; j < cnt; j++) begin
         ck_b <= 1'b1;
         repeat (8) @(posedge clk);
         w = {w[14:0], lnk_b.serial_result_line};
         ck_b <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask

   task automatic convert_b(input logic keep_low);
      int n;
      cv_b <= 1'b0;
      repeat (5) @(posedge clk);
      cv_b <= ~keep_low;
      wait_hi(2, 20, n);
      wait_hi(3, CONV + 1, n);
      repeat (20) @(posedge clk);
   endtask

   function automatic logic [15:0] bip(input logic [11:0] s);
      return {4'h0, ~s[11], s[10:0]};
   endfunction

   // Hang guard, sized well above the expected run
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      $display("Error watchdog expected finish seen timeout");
      stop_test;
   end

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial begin
      logic [15:0] w;
      int n;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) run_row(ROWS[i]);
      // Hand-driven converter: two's complement frame, then release
      sample_b <= 12'h3c5;
      convert_b(1'b0);
      read_b(16, w);
      check("bip_frame", bip(12'h3c5), w);
      repeat (6) @(posedge clk);
      check("oe_n_16", 16'h0001, {15'h0, lnk_b.serial_result_oe_n});
      read_b(6, w);
      check("extra_bits", bip(12'h3c5) >> 10, w);
      check("oe_n_extra", 16'h0000, {15'h0, lnk_b.serial_result_oe_n});
      sample_b <= 12'h801;
      convert_b(1'b0);
      check("oe_n_conv", 16'h0001, {15'h0, lnk_b.serial_result_oe_n});
      read_b(5, w);
      sample_b <= 12'h07e;
      convert_b(1'b0);
      read_b(16, w);
      check("span_frame", bip(12'h07e), w);
      // Sleep, read while asleep, then a long wake pulse
      sample_b <= 12'hfff;
      convert_b(1'b1);
      check("asl_b", 16'h0001, {15'h0, asl_b});
      read_b(16, w);
      check("sleep_frame", bip(12'hfff), w);
      repeat (20) @(posedge clk);
      cv_b <= 1'b1;
      repeat (WAKE + 20) @(posedge clk);
      check("no_hold", 16'h0000, {15'h0, lnk_b.conversion_busy});
      sample_b <= 12'h000;
      cv_b <= 1'b0;
      wait_hi(2, 8, n);
      cv_b <= 1'b1;
      wait_hi(3, CONV + 1, n);
      repeat (20) @(posedge clk);
      read_b(16, w);
      check("long_frame", bip(12'h000), w);
      // Reset in mid-conversion, then recovery
      wait_hi(0, 3000, n);
      sleep_mode <= 1'b0;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check("reset_state", 16'h0027, {10'h0, lnk_a.convert_start_n,
         lnk_a.serial_clock, lnk_a.conversion_busy,
         lnk_a.serial_result_oe_n, tracking, ready});
      run_row(ROWS[3]);
      stop_test;
   end
endmodule
